//--- rtl/ipsp_top.sv
// Input-only ports, serial pin control register and serial data inversion behind an APB slave.
`timescale 1ns/10ps
`include "ipsp_defs.svh"

module ipsp_top
	import ipsp_pkg::*;
#(
	parameter int WIDE_W = 8,
	parameter int NARROW_W = 4
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire ipsp_apb_req_t apb_req_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [WIDE_W-1:0] wide_port_pins_i,
	input wire logic [NARROW_W-1:0] narrow_port_pins_i,
	input wire logic [3:0] analog_channel_select_i,
	input wire logic first_receive_pin_i,
	input wire logic second_receive_pin_i,
	output logic rx_first_data_o,
	output logic rx_second_data_o,
	input wire logic tx_first_data_i,
	input wire logic tx_second_data_i,
	input wire ipsp_pin_drive_t gpio_first_drive_i,
	input wire ipsp_pin_drive_t gpio_second_drive_i,
	input wire logic first_shared_gpio_i,
	input wire logic second_shared_gpio_i,
	output logic first_shared_gpio_o,
	output logic first_shared_gpio_oe_o,
	output logic second_shared_gpio_o,
	output logic second_shared_gpio_oe_o,
	output logic gpio_first_in_o,
	output logic gpio_second_in_o,
	output ipsp_spc_t serial_pin_control_o
);

	generate
		if (WIDE_W < 1 || WIDE_W > 8) begin : g_wide_chk
			$error("WIDE_W must lie between 1 and 8.");
		end
		if (NARROW_W < 1 || NARROW_W > 4) begin : g_narrow_chk
			$error("NARROW_W must lie between 1 and 4.");
		end
	endgenerate

	ipsp_spc_t ctrl_ff;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic pready_ff;
	logic pslverr_ff;
	logic nxt_pslverr;
	logic gpio_first_in_ff;
	logic gpio_second_in_ff;
	logic [WIDE_W-1:0] wide_an_mask;
	logic [NARROW_W-1:0] narrow_an_mask;
	logic [7:0] wide_rd;
	logic [7:0] narrow_rd;
	logic setup;
	logic wr_done;
	logic hit_spc;
	logic hit_wide;
	logic hit_narrow;

	assign setup = psel_i & ~penable_i;
	assign hit_spc = apb_req_i.paddr == `IPSP_SPC_ADDR;
	assign hit_wide = apb_req_i.paddr == `IPSP_WIDE_ADDR;
	assign hit_narrow = apb_req_i.paddr == `IPSP_NARROW_ADDR;
	assign wr_done = psel_i & penable_i & pready_ff & apb_req_i.pwrite;

	// Channel codes from the base upward claim wide pins, then narrow pins.
	always_comb begin
		for (int k = 0; k < WIDE_W; k++) begin
			wide_an_mask[k] = analog_channel_select_i == (`IPSP_WIDE_CH_BASE + 4'(k));
		end
		for (int k = 0; k < NARROW_W; k++) begin
			narrow_an_mask[k] = analog_channel_select_i == (`IPSP_NARROW_CH_BASE + 4'(k));
		end
	end

	// Port reads sample the pins directly; there is no data latch behind them.
	always_comb begin
		wide_rd = 8'h00;
		wide_rd[WIDE_W-1:0] = wide_port_pins_i & ~wide_an_mask;
		narrow_rd = `IPSP_NARROW_PAD | 8'h0F;
		narrow_rd[NARROW_W-1:0] = narrow_port_pins_i & ~narrow_an_mask;
	end

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		nxt_pslverr = 1'b0;
		if (hit_spc) begin
			nxt_prdata[7:0] = ctrl_ff | `IPSP_SPC_RSVD;
		end else if (hit_wide) begin
			nxt_prdata[7:0] = wide_rd;
		end else if (hit_narrow) begin
			nxt_prdata[7:0] = narrow_rd;
		end else begin
			nxt_pslverr = 1'b1;
		end
	end

	// Zero wait states: pready rises in the first access cycle of every transfer.
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= setup;
			if (setup) begin
				pslverr_ff <= nxt_pslverr;
				prdata_ff <= apb_req_i.pwrite ? 32'h0000_0000 : nxt_prdata;
			end else begin
				pslverr_ff <= 1'b0;
			end
		end
	end

	// Only the control register takes writes; port data registers ignore them.
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ctrl_ff <= ipsp_spc_t'(`IPSP_SPC_RST);
		end else if (wr_done && hit_spc) begin
			ctrl_ff <= ipsp_spc_t'((apb_req_i.pwdata[7:0] & `IPSP_SPC_WMASK) | `IPSP_SPC_RSVD);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			gpio_first_in_ff <= 1'b0;
			gpio_second_in_ff <= 1'b0;
		end else begin
			gpio_first_in_ff <= first_shared_gpio_i;
			gpio_second_in_ff <= second_shared_gpio_i;
		end
	end

	// The serial data paths stay combinational so an inversion change acts at once.
	assign rx_first_data_o = first_receive_pin_i ^ ctrl_ff.rx_first_invert;
	assign rx_second_data_o = second_receive_pin_i ^ ctrl_ff.rx_second_invert;

	always_comb begin
		if (ctrl_ff.first_tx_pin_select) begin
			first_shared_gpio_o = tx_first_data_i ^ ctrl_ff.tx_first_invert;
			first_shared_gpio_oe_o = 1'b1;
		end else begin
			first_shared_gpio_o = gpio_first_drive_i.out;
			first_shared_gpio_oe_o = gpio_first_drive_i.oe;
		end
		if (ctrl_ff.second_tx_pin_select) begin
			second_shared_gpio_o = tx_second_data_i ^ ctrl_ff.tx_second_invert;
			second_shared_gpio_oe_o = 1'b1;
		end else begin
			second_shared_gpio_o = gpio_second_drive_i.out;
			second_shared_gpio_oe_o = gpio_second_drive_i.oe;
		end
	end

	assign prdata_o = prdata_ff;
	assign pready_o = pready_ff;
	assign pslverr_o = pslverr_ff;
	assign gpio_first_in_o = gpio_first_in_ff;
	assign gpio_second_in_o = gpio_second_in_ff;
	assign serial_pin_control_o = ctrl_ff;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	logic rd_wide_acc;
	logic rd_narrow_acc;
	logic rd_spc_acc;
	logic wr_spc_acc;
	logic wr_other_acc;

	assign rd_wide_acc = pready_o && psel_i && penable_i && !apb_req_i.pwrite && hit_wide;
	assign rd_narrow_acc = pready_o && psel_i && penable_i && !apb_req_i.pwrite && hit_narrow;
	assign rd_spc_acc = pready_o && psel_i && penable_i && !apb_req_i.pwrite && hit_spc;
	assign wr_spc_acc = pready_o && psel_i && penable_i && apb_req_i.pwrite && hit_spc;
	assign wr_other_acc = pready_o && psel_i && penable_i && apb_req_i.pwrite && !hit_spc;

	pready_pulse_a: assert property (
		setup |=> pready_o ##1 !pready_o
	) else $error("pready did not pulse for one cycle after setup.");

	wide_level_a: assert property (
		rd_wide_acc |-> prdata_o[WIDE_W-1:0] ==
			($past(wide_port_pins_i) & ~$past(wide_an_mask)) && prdata_o[31:8] == 24'h000000
	) else $error("wide port read does not match sampled pins.");

	wide_analog_a: assert property (
		rd_wide_acc && $past(analog_channel_select_i) == `IPSP_WIDE_CH_BASE
		|-> prdata_o[0] == 1'b0
	) else $error("analog wide pin did not read zero.");

	wide_drive_a: assert property (
		rd_wide_acc && $past(analog_channel_select_i) < `IPSP_WIDE_CH_BASE
		|-> prdata_o[WIDE_W-1:0] == $past(wide_port_pins_i)
	) else $error("digital wide pins not returned unchanged.");

	narrow_level_a: assert property (
		rd_narrow_acc && $past(analog_channel_select_i) < `IPSP_WIDE_CH_BASE
		|-> prdata_o[NARROW_W-1:0] == $past(narrow_port_pins_i)
	) else $error("narrow port read does not match sampled pins.");

	narrow_analog_a: assert property (
		rd_narrow_acc |-> (prdata_o[NARROW_W-1:0] & $past(narrow_an_mask)) == '0
	) else $error("analog narrow pin did not read zero.");

	narrow_pad_a: assert property (
		rd_narrow_acc |-> prdata_o[7:4] == 4'hF && prdata_o[31:8] == 24'h000000
	) else $error("narrow port upper bits not read as one.");

	port_ro_a: assert property (
		wr_other_acc |=> $stable(ctrl_ff)
	) else $error("write to a port register changed the control register.");

	spc_reset_a: assert property (
		$rose(nrst_i) |-> ctrl_ff == ipsp_spc_t'(`IPSP_SPC_RST)
	) else $error("control register not at its reset value.");

	spc_write_a: assert property (
		wr_spc_acc |=> ctrl_ff == ipsp_spc_t'(($past(apb_req_i.pwdata[7:0]) & 8'h3F) | 8'hC0)
	) else $error("control write not stored with reserved bits set.");

	spc_rsvd_a: assert property (
		rd_spc_acc |-> prdata_o[7:6] == 2'b11
	) else $error("reserved control bits did not read one.");

	rx_first_a: assert property (
		wr_spc_acc |=> rx_first_data_o ==
			(first_receive_pin_i ^ $past(apb_req_i.pwdata[0]))
	) else $error("first receive path wrong.");

	rx_second_a: assert property (
		$changed(ctrl_ff.rx_second_invert) && $stable(second_receive_pin_i)
		|-> $changed(rx_second_data_o)
	) else $error("second receive inversion not immediate.");

	inv_immediate_a: assert property (
		wr_spc_acc ##1 ($changed(ctrl_ff.rx_first_invert) && $stable(first_receive_pin_i))
		|-> $changed(rx_first_data_o)
	) else $error("first receive inversion change delayed.");

	tx_first_a: assert property (
		ctrl_ff.first_tx_pin_select |->
			first_shared_gpio_oe_o && first_shared_gpio_o == (tx_first_data_i ^ ctrl_ff.tx_first_invert)
	) else $error("first transmit pin wrong.");

	gpio_first_a: assert property (
		!ctrl_ff.first_tx_pin_select |-> first_shared_gpio_o == gpio_first_drive_i.out &&
			first_shared_gpio_oe_o == gpio_first_drive_i.oe
	) else $error("first shared pin not in GPIO use.");

	tx_second_a: assert property (
		ctrl_ff.second_tx_pin_select |-> second_shared_gpio_oe_o &&
			second_shared_gpio_o == (tx_second_data_i ^ ctrl_ff.tx_second_invert)
	) else $error("second transmit pin wrong.");

	gpio_second_a: assert property (
		!ctrl_ff.second_tx_pin_select |-> second_shared_gpio_o == gpio_second_drive_i.out
	) else $error("second shared pin not in GPIO use.");

	unmapped_err_a: assert property (
		pslverr_o |-> pready_o
	) else $error("slave error outside an access cycle.");

	// The first of these checks take the expected control bits from the register; the later write checks take them from the bus write.
	spc_hold_a: assert property (
		!wr_spc_acc |=> $stable(ctrl_ff)
	) else $error("control register changed without a write.");

	rsvd_ones_a: assert property (
		ctrl_ff.rsvd == 2'b11
	) else $error("reserved control bits lost their ones.");

	spc_read_a: assert property (
		rd_spc_acc |-> prdata_o == {24'h000000, $past(ctrl_ff)}
	) else $error("control read does not return the register.");

	err_data_a: assert property (
		pslverr_o |-> prdata_o == 32'h0000_0000
	) else $error("unmapped access returned data.");

	prdata_hold_a: assert property (
		!setup |=> $stable(prdata_o)
	) else $error("read data changed outside a setup cycle.");

	mapped_ok_a: assert property (
		pready_o && (hit_spc || hit_wide || hit_narrow) |-> !pslverr_o
	) else $error("mapped register answered with an error.");

	rx_second_wr_a: assert property (
		wr_spc_acc |=> rx_second_data_o ==
			(second_receive_pin_i ^ $past(apb_req_i.pwdata[2]))
	) else $error("second receive inversion not taken from the write.");

	tx_first_wr_a: assert property (
		wr_spc_acc && apb_req_i.pwdata[4] |=> first_shared_gpio_oe_o &&
			first_shared_gpio_o == (tx_first_data_i ^ $past(apb_req_i.pwdata[1]))
	) else $error("first transmit inversion not taken from the write.");

	tx_second_wr_a: assert property (
		wr_spc_acc && apb_req_i.pwdata[5] |=> second_shared_gpio_oe_o &&
			second_shared_gpio_o == (tx_second_data_i ^ $past(apb_req_i.pwdata[3]))
	) else $error("second transmit inversion not taken from the write.");

	line_first_a: assert property (
		$past(nrst_i) |-> gpio_first_in_o == $past(first_shared_gpio_i)
	) else $error("first shared pin level not registered.");

	line_second_a: assert property (
		$past(nrst_i) |-> gpio_second_in_o == $past(second_shared_gpio_i)
	) else $error("second shared pin level not registered.");

	spc_write_c: cover property (wr_spc_acc ##1 ctrl_ff.first_tx_pin_select);
	wide_mask_c: cover property (rd_wide_acc && $past(wide_an_mask) != '0);
	tx_invert_c: cover property (ctrl_ff.second_tx_pin_select && ctrl_ff.tx_second_invert);
	narrow_read_c: cover property (rd_narrow_acc);
	inv_flip_c: cover property (wr_spc_acc ##1 $changed(ctrl_ff.rx_first_invert));

endmodule

//--- rtl/ipsp_defs.svh
// Register indices, byte addresses, field positions and reset values of the input port block.
`ifndef IPSP_DEFS_SVH
`define IPSP_DEFS_SVH

`define IPSP_SPC_IDX 16'hFF91
`define IPSP_WIDE_IDX 16'hFFDE
`define IPSP_NARROW_IDX 16'hFFDF

`define IPSP_SPC_ADDR {`IPSP_SPC_IDX, 2'b00}
`define IPSP_WIDE_ADDR {`IPSP_WIDE_IDX, 2'b00}
`define IPSP_NARROW_ADDR {`IPSP_NARROW_IDX, 2'b00}

`define IPSP_RX_FIRST_INV_BIT 0
`define IPSP_TX_FIRST_INV_BIT 1
`define IPSP_RX_SECOND_INV_BIT 2
`define IPSP_TX_SECOND_INV_BIT 3
`define IPSP_FIRST_SEL_BIT 4
`define IPSP_SECOND_SEL_BIT 5

`define IPSP_SPC_RST 8'hC0
`define IPSP_SPC_RSVD 8'hC0
`define IPSP_SPC_WMASK 8'h3F
`define IPSP_NARROW_PAD 8'hF0

`define IPSP_WIDE_CH_BASE 4'h4
`define IPSP_NARROW_CH_BASE 4'hC

`endif

//--- rtl/ipsp_pkg.sv
// Types shared by the input port and serial pin inversion block.
package ipsp_pkg;

	typedef struct packed {
		logic [17:0] paddr;
		logic pwrite;
		logic [31:0] pwdata;
	} ipsp_apb_req_t;

	typedef struct packed {
		logic [1:0] rsvd;
		logic second_tx_pin_select;
		logic first_tx_pin_select;
		logic tx_second_invert;
		logic rx_second_invert;
		logic tx_first_invert;
		logic rx_first_invert;
	} ipsp_spc_t;

	typedef struct packed {
		logic out;
		logic oe;
	} ipsp_pin_drive_t;

endpackage

//--- tb/ipsp_pin_model.sv
// Model of the external pins and serial channels around the port block.
`timescale 1ns/10ps
module ipsp_pin_model (
	input wire logic [15:0] pat_i,
	input wire logic out1_i,
	input wire logic oe1_i,
	input wire logic out2_i,
	input wire logic oe2_i,
	output logic [7:0] wide_o,
	output logic [3:0] narrow_o,
	output logic rx1_o,
	output logic rx2_o,
	output logic tx1_o,
	output logic tx2_o,
	output logic line1_o,
	output logic line2_o
);
	// The board drives every input pin except the two shared lines; the port drives those while its output enable is set.
	assign wide_o = pat_i[7:0];
	assign narrow_o = pat_i[11:8];
	assign rx1_o = pat_i[12];
	assign rx2_o = pat_i[13];
	assign tx1_o = pat_i[14];
	assign tx2_o = pat_i[15];
	// A shared line follows the block while it drives, else the outside device.
	assign line1_o = oe1_i ? out1_i : pat_i[4];
	assign line2_o = oe2_i ? out2_i : pat_i[5];
endmodule

//--- tb/testbench.sv
// Self-checking bench for the input port and serial pin inversion block.
`timescale 1ns/10ps
`include "ipsp_defs.svh"
module testbench;
	import ipsp_pkg::*;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	ipsp_apb_req_t req = '0;
	logic [15:0] pat = 16'h0035;
	logic [15:0] lfsr_st = 16'h0035;
	logic [3:0] ach = 4'h0;
	ipsp_pin_drive_t g1 = '0;
	ipsp_pin_drive_t g2 = '0;
	logic [31:0] prdata_o, rd;
	logic pready_o, pslverr_o, err, rx1, rx2, tx1, tx2, l1, l2;
	logic o1, e1, o2, e2, i1, i2, pr1, pr2;
	logic [7:0] wide;
	logic [3:0] narrow;
	ipsp_spc_t spc;
	int miscompares = 0;
	int checks = 0;
	int cyc = 0;
	always #10 clk_i = ~clk_i;
	ipsp_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
		.apb_req_i(req), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.wide_port_pins_i(wide), .narrow_port_pins_i(narrow), .analog_channel_select_i(ach),
		.first_receive_pin_i(pr1), .second_receive_pin_i(pr2), .rx_first_data_o(rx1),
		.rx_second_data_o(rx2), .tx_first_data_i(tx1), .tx_second_data_i(tx2),
		.gpio_first_drive_i(g1), .gpio_second_drive_i(g2), .first_shared_gpio_i(l1),
		.second_shared_gpio_i(l2), .first_shared_gpio_o(o1), .first_shared_gpio_oe_o(e1),
		.second_shared_gpio_o(o2), .second_shared_gpio_oe_o(e2), .gpio_first_in_o(i1),
		.gpio_second_in_o(i2), .serial_pin_control_o(spc));
	ipsp_pin_model far (.pat_i(pat), .out1_i(o1), .oe1_i(e1), .out2_i(o2), .oe2_i(e2),
		.wide_o(wide), .narrow_o(narrow), .rx1_o(pr1), .rx2_o(pr2), .tx1_o(tx1),
		.tx2_o(tx2), .line1_o(l1), .line2_o(l2));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic int port_exp(input int pins, input int ch, input int base, input int pad);
		int m = 0;
		if (ch >= base && ch < base + 8) begin
			m = 1 << (ch - base);
		end
		return pad | (pins & ~m & ~pad & 255);
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic [17:0] a, input logic w, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		req <= '{paddr: a, pwrite: w, pwdata: d};
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			miscompares++;
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic pin_chk(input int c);
		chk("control copy", 32'hC0 | c, {24'h0, spc});
		chk("rx first", pat[12] ^ c[0], rx1);
		chk("rx second", pat[13] ^ c[2], rx2);
		chk("first oe", c[4] ? 1 : g1.oe, e1);
		chk("first out", c[4] ? pat[14] ^ c[1] : g1.out, o1);
		chk("second oe", c[5] ? 1 : g2.oe, e2);
		chk("second out", c[5] ? pat[15] ^ c[3] : g2.out, o2);
		@(posedge clk_i);
		@(posedge clk_i);
		chk("first line in", l1, i1);
		chk("second line in", l2, i2);
	endtask
	task automatic final_report;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			final_report();
		end
	end
	initial begin
		repeat (12) @(posedge clk_i);
		nrst_i <= 1'b1;
		chk("control reset", `IPSP_SPC_RST, {24'h0, spc});
		apb(`IPSP_SPC_ADDR, 1'b0, 32'h0);
		chk("control read", 32'hC0, rd);
		apb(`IPSP_SPC_ADDR, 1'b1, 32'hFFFFFF00);
		apb(`IPSP_SPC_ADDR, 1'b0, 32'h0);
		chk("reserved bits", 32'hC0, rd);
		chk("mapped error", 32'h0, err);
		apb(18'h00010, 1'b0, 32'h0);
		chk("unmapped error", 32'h1, err);
		chk("unmapped data", 32'h0, rd);
		for (int i = 0; i < 16; i++) begin
			pat <= lfsr_st;
			ach <= i[3:0];
			lfsr_st = lfsr(lfsr_st);
			apb(`IPSP_WIDE_ADDR, 1'b1, 32'hFF);
			apb(`IPSP_NARROW_ADDR, 1'b1, 32'h0);
			apb(`IPSP_WIDE_ADDR, 1'b0, 32'h0);
			chk("wide port", port_exp(pat[7:0], i, 4, 0), rd);
			apb(`IPSP_NARROW_ADDR, 1'b0, 32'h0);
			chk("narrow port", port_exp(pat[11:8], i, 12, 240), rd);
		end
		for (int c = 0; c < 64; c++) begin
			pat <= lfsr_st;
			g1 <= lfsr_st[3:2];
			g2 <= lfsr_st[1:0];
			lfsr_st = lfsr(lfsr_st);
			apb(`IPSP_SPC_ADDR, 1'b1, c);
			#1;
			pin_chk(c);
		end
		final_report();
	end
endmodule
